// >>> logic/csh_defs.svh
// Constants for the coherency and snapshot handshakes.
`ifndef CSH_DEFS_SVH
`define CSH_DEFS_SVH
`define CSH_CNT_W 32
`define CSH_NUM_CNT 4
`define CSH_CNT_RST 32'h0000_0000
`define CSH_CNT_ONE 32'h0000_0001
`define CSH_FLAG_RST 1'b0
`endif

// >>> logic/csh_pkg.sv
// Types shared by the coherency and snapshot handshake logic.
`include "csh_defs.svh"
package csh_pkg;
    typedef enum logic [1:0] {
        CSH_OUT = 2'b00,
        CSH_JOINING = 2'b01,
        CSH_IN = 2'b10,
        CSH_LEAVING = 2'b11
    } csh_coh_e;
    typedef logic [`CSH_CNT_W-1:0] csh_cnt_t;
endpackage : csh_pkg

// >>> logic/csh_handshakes.sv
// Coherency request and counter snapshot sideband handshakes.
`timescale 1ns/10ps
`include "csh_defs.svh"
module csh_handshakes
    import csh_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Coherency handshake with the interconnect.
    input wire logic cohWant,
    output logic cohReq,
    input wire logic cohAck,
    output logic cohInDomain,
    output logic cohBusy,
    // Counter event inputs.
    input wire logic [`CSH_NUM_CNT-1:0] cntEvent,
    // Snapshot handshake with the debug side.
    input wire logic snapReq,
    output logic snapAck,
    output csh_cnt_t snapVal [`CSH_NUM_CNT]
);
    // ------------------------------------------------------------
    // Coherency state machine
    // ------------------------------------------------------------
    csh_coh_e cohState_r;
    logic cohReq_r;

    // single domain: everything runs on sys_clk with rst.
    // request hold: a new level starts only once acked.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cohState_r <= CSH_OUT;
            cohReq_r <= `CSH_FLAG_RST;
        end else begin
            unique case (cohState_r)
                CSH_OUT: begin
                    if (cohWant && !cohAck) begin
                        cohReq_r <= 1'b1;
                        cohState_r <= CSH_JOINING;
                    end
                end
                CSH_JOINING: begin
                    if (cohAck) begin
                        cohState_r <= CSH_IN;
                    end
                end
                CSH_IN: begin
                    if (!cohWant && cohAck) begin
                        cohReq_r <= 1'b0;
                        cohState_r <= CSH_LEAVING;
                    end
                end
                CSH_LEAVING: begin
                    if (!cohAck) begin
                        cohState_r <= CSH_OUT;
                    end
                end
            endcase
        end
    end

    assign cohReq = cohReq_r;
    // ack follow: busy while acknowledge lags request.
    assign cohBusy = (cohState_r == CSH_JOINING) ||
                     (cohState_r == CSH_LEAVING);
    assign cohInDomain = (cohState_r == CSH_IN);

    // ------------------------------------------------------------
    // Coherency checks
    // ------------------------------------------------------------
    // join starts
    join_start_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cohState_r == CSH_OUT && cohWant && !cohAck) |=> cohReq)
        else $error("join request not raised");

    join_busy_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(cohReq) |-> cohBusy)
        else $error("join request raised without busy");

    in_level_a: assert property (@(posedge sys_clk) disable iff (rst)
        cohInDomain |-> cohReq)
        else $error("in domain with request low");

    leave_start_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cohState_r == CSH_IN && !cohWant && cohAck) |=> !cohReq)
        else $error("leave request not raised");

    out_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cohState_r == CSH_OUT) |-> !cohReq)
        else $error("request high while out of domain");

    leave_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!cohReq && cohAck) |=> !cohReq)
        else $error("coherency exit request dropped before acknowledge");

    join_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cohReq && !cohAck) |=> cohReq)
        else $error("coherency request dropped before acknowledge");

    req_stable_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cohBusy && (cohAck != cohReq)) |=> $stable(cohReq))
        else $error("coherency request moved while acknowledge lagged");

    busy_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cohBusy && (cohAck == cohReq)) |=> !cohBusy)
        else $error("busy stays after acknowledge matched");

    // ------------------------------------------------------------
    // Counters and snapshot
    // ------------------------------------------------------------
    logic snapReqDly_r;
    logic snapAck_r;
    logic snapEdge;
    csh_cnt_t count_r [`CSH_NUM_CNT];
    csh_cnt_t snap_r [`CSH_NUM_CNT];

    // edge detect: only a low-to-high request triggers a capture.
    assign snapEdge = snapReq && !snapReqDly_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            snapReqDly_r <= `CSH_FLAG_RST;
        end else begin
            snapReqDly_r <= snapReq;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `CSH_NUM_CNT; gi++) begin : g_cnt
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    count_r[gi] <= `CSH_CNT_RST;
                end else if (cntEvent[gi]) begin
                    count_r[gi] <= count_r[gi] + `CSH_CNT_ONE;
                end
            end
            // counter capture: values frozen on the edge.
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    snap_r[gi] <= `CSH_CNT_RST;
                end else if (snapEdge) begin
                    snap_r[gi] <= count_r[gi];
                end
            end
            assign snapVal[gi] = snap_r[gi];
        end
    endgenerate

    // Acknowledge mirrors the request level once the capture is done,
    // so the debug side sees a four-phase style completion.
    // ack report: low from reset, high after a snapshot.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            snapAck_r <= `CSH_FLAG_RST;
        end else if (snapEdge) begin
            snapAck_r <= 1'b1;
        end else if (!snapReq) begin
            snapAck_r <= 1'b0;
        end
    end
    assign snapAck = snapAck_r;

    // ------------------------------------------------------------
    // Snapshot checks
    // ------------------------------------------------------------
    // ack after edge
    snap_ack_a: assert property (@(posedge sys_clk) disable iff (rst)
        (snapReq && !$past(snapReq)) |=> snapAck)
        else $error("snapshot not acknowledged");

    ack_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (snapAck && snapReq) |=> snapAck)
        else $error("snapshot acknowledge dropped early");

    ack_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
        !snapReq |=> !snapAck)
        else $error("snapshot acknowledge stuck high");

    ack_reset_a: assert property (@(posedge sys_clk)
        rst |=> !snapAck)
        else $error("snapshot acknowledge high after reset");

    ack_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(snapAck) |-> $past(snapEdge))
        else $error("snapshot acknowledge without request edge");

    snap_value_a: assert property (@(posedge sys_clk) disable iff (rst)
        snapEdge |=> (snapVal[0] == $past(count_r[0])))
        else $error("snapshot value wrong");

    snap_last_a: assert property (@(posedge sys_clk) disable iff (rst)
        snapEdge |=> (snapVal[`CSH_NUM_CNT-1] ==
                      $past(count_r[`CSH_NUM_CNT-1])))
        else $error("last snapshot value wrong");

    snap_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !snapEdge |=> $stable(snapVal[0]))
        else $error("snapshot value changed without request edge");

    count_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        cntEvent[0] |=>
            (count_r[0] == $past(count_r[0]) + `CSH_CNT_ONE))
        else $error("counter missed an event");

    count_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
        !cntEvent[`CSH_NUM_CNT-1] |=>
            $stable(count_r[`CSH_NUM_CNT-1]))
        else $error("counter moved without an event");
endmodule : csh_handshakes

// >>> bench/csh_icn_model.sv
// Interconnect model that answers the coherency request after a lag.
`timescale 1ns/10ps
module csh_icn_model (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Coherency handshake and answer lag in cycles.
    input wire logic cohReq,
    input wire logic [3:0] lag,
    output logic cohAck
);
    logic [3:0] waitCnt_r;
    always_ff @(posedge sys_clk) begin
        if (rst || cohAck == cohReq) waitCnt_r <= 4'h0;
        else waitCnt_r <= waitCnt_r + 4'h1;
        if (rst) cohAck <= 1'b0;
        else if (cohAck != cohReq && waitCnt_r >= lag) cohAck <= cohReq;
    end
endmodule : csh_icn_model

// >>> bench/tb_top.sv
// Self-checking bench for the coherency and snapshot handshakes.
`timescale 1ns/10ps
`include "csh_defs.svh"
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin \
    miscompares++; $display("unexpected %0t %h %h", $time, a, b); end end
module tb_top import csh_pkg::*;;
    logic sys_clk = 1'b0, rst = 1'b1, cohWant = 1'b0;
    logic snapReq = 1'b0, evOn = 1'b1;
    logic cohReq, cohAck, cohInDomain, cohBusy, snapAck;
    logic [3:0] cntEvent = 4'h0, lag = 4'h0;
    logic [31:0] lfsr = 32'h2FD873E9;
    csh_cnt_t snapVal [`CSH_NUM_CNT], expCnt [`CSH_NUM_CNT], held;
    int miscompares = 0, samplesChecked = 0;
    csh_handshakes DUT (.sys_clk(sys_clk), .rst(rst), .cohWant(cohWant),
        .cohReq(cohReq), .cohAck(cohAck), .cohInDomain(cohInDomain),
        .cohBusy(cohBusy), .cntEvent(cntEvent), .snapReq(snapReq),
        .snapAck(snapAck), .snapVal(snapVal));
    csh_icn_model icn (.sys_clk(sys_clk), .rst(rst), .cohReq(cohReq),
        .lag(lag), .cohAck(cohAck));
    function automatic logic [31:0] lfsrStep(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsrStep
    // Expected counter value after one edge, wrapping like the hardware.
    function automatic csh_cnt_t nextCount(input csh_cnt_t c,
        input logic ev, input logic clr);
        return clr ? `CSH_CNT_RST : c + csh_cnt_t'(ev);
    endfunction : nextCount
    task automatic stopTest;
        $display("checks %0d miscompares %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stopTest
    task automatic waitIdle;
        for (int n = 0; cohBusy !== 1'b0; n++) begin
            if (n > 60) begin
                miscompares++;
                stopTest();
            end
            @(posedge sys_clk);
            #1;
        end
    endtask : waitIdle
    initial forever #2 sys_clk = ~sys_clk;
    // Expected counts track events exactly as the counters sample them.
    always @(posedge sys_clk) begin
        lfsr <= lfsrStep(lfsr);
        cntEvent <= evOn ? lfsr[3:0] : 4'h0;
        for (int i = 0; i < `CSH_NUM_CNT; i++)
            expCnt[i] <= nextCount(expCnt[i], cntEvent[i], rst);
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        `CHK(snapAck, 1'b0)
        `CHK(cohReq, 1'b0)
        for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            lag <= (k == 0) ? 4'h0 : lfsr[7:4];
            cohWant <= ~k[0];
            @(posedge sys_clk);
            cohWant <= k[0];
            @(posedge sys_clk);
            cohWant <= ~k[0];
            #1;
            `CHK(cohReq, ~k[0])
            `CHK(cohBusy, 1'b1)
            waitIdle();
            `CHK(cohReq, ~k[0])
            `CHK(cohAck, ~k[0])
            `CHK(cohInDomain, ~k[0])
        end
        // Reset in the middle of a join and a snapshot clears both sides.
        @(posedge sys_clk);
        cohWant <= 1'b1;
        snapReq <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK(snapAck, 1'b1)
        `CHK(cohReq, 1'b1)
        @(posedge sys_clk);
        rst <= 1'b1;
        cohWant <= 1'b0;
        snapReq <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        `CHK(snapAck, 1'b0)
        `CHK(cohReq, 1'b0)
        `CHK(cohBusy, 1'b0)
        `CHK(snapVal[0], `CSH_CNT_RST)
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            evOn <= 1'b0;
            repeat (3) @(posedge sys_clk);
            snapReq <= 1'b1;
            repeat (2) @(posedge sys_clk);
            #1;
            for (int i = 0; i < 4; i++) `CHK(snapVal[i], expCnt[i])
            `CHK(snapAck, 1'b1)
            held = snapVal[0];
            @(posedge sys_clk);
            evOn <= 1'b1;
            repeat (5) @(posedge sys_clk);
            snapReq <= 1'b0;
            #1;
            `CHK(snapVal[0], held)
            repeat (2) @(posedge sys_clk);
            #1;
            `CHK(snapAck, 1'b0)
        end
        stopTest();
    end
endmodule : tb_top
